// [core/sleep_clock_gating.v]
// clock gate control for the sleep power mode, with run, sleep and deep sets and fault checking
// assumes a one-cycle register port and a peripheral access strobe from the bus fabric
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`include "sleep_clock_gating_regs.vh"

// Notes on behaviour
// - each gate bit enables one unit's clock
// - access to a gated unit gives bus fault, except hibernate, which never faults
// - gate bits reset cleared unless noted
// - run, sleep and deep-sleep sets exist
// - sleep set applies only with auto-gate select
// - bit 20 gates PWM, resets zero
// - bit 16 gates ADC, resets zero
// - bit 3 gates watchdog, resets zero
// - bit 6 gates hibernate, resets one
// - bits 9:8 choose ADC sample rate
module sleep_clock_gating (
	clk_sys,
	rst,
	regAddr,
	regWrData,
	regWrStb,
	regRdStb,
	regRdData,
	periphAccess,
	periphUnit,
	busFault,
	pwmClkEn,
	adcClkEn,
	watchdogClkEn,
	hibernateClkEn,
	adcSampleRate,
	irq
);
	input wire clk_sys;
	input wire rst;
	input wire [11:0] regAddr;
	input wire [31:0] regWrData;
	input wire regWrStb;
	input wire regRdStb;
	output reg [31:0] regRdData;
	input wire periphAccess;
	input wire [1:0] periphUnit;
	output reg busFault;
	output reg pwmClkEn;
	output reg adcClkEn;
	output reg watchdogClkEn;
	output reg hibernateClkEn;
	output reg [1:0] adcSampleRate;
	output reg irq;

	// ======================================================================
	// states of the fault answer
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_FAULT = 2'b10;

	// ======================================================================
	// storage
	// gate sets, configuration and mode
	reg [31:0] runGate_q;
	reg [31:0] sleepGate_q;
	reg [31:0] deepGate_q;
	reg [31:0] runCfg_q;
	reg [1:0] powerMode_q;

	// events and interrupt
	reg [`SCG_EV_WIDTH-1:0] status_q;
	reg [`SCG_EV_WIDTH-1:0] mask_q;
	reg [`SCG_EV_WIDTH-1:0] status_d;
	wire [`SCG_EV_WIDTH-1:0] events;

	// fault answer
	reg [1:0] state_q;
	reg [1:0] state_d;
	wire faultNow;

	// active set and read path
	reg [31:0] activeGate_q;
	wire [31:0] activeGate;
	wire gateChanged;
	reg [31:0] rdMux;

	// ======================================================================
	// decoding helpers
	// register write hit: strobe and exact address
	function wrHit;
		input stb;
		input [11:0] addr;
		input [11:0] off;
		begin
			wrHit = stb && (addr == off);
		end
	endfunction

	// gate bit that clocks a given unit
	function unitEnabled;
		input [31:0] gate;
		input [1:0] unit;
		begin
			case (unit)
				`SCG_UNIT_PWM: unitEnabled = gate[`SCG_BIT_PWM];
				`SCG_UNIT_ADC: unitEnabled = gate[`SCG_BIT_ADC];
				`SCG_UNIT_WDT: unitEnabled = gate[`SCG_BIT_WDT];
				default: unitEnabled = 1'b1; // hibernate never faults
			endcase
		end
	endfunction

	// ======================================================================
	// active set chooser
	gate_set_select uSelect (
		.runGate(runGate_q),
		.sleepGate(sleepGate_q),
		.deepGate(deepGate_q),
		.powerMode(powerMode_q),
		.autoGateSel(runCfg_q[`SCG_BIT_ACG]),
		.activeGate(activeGate)
	);

	// ======================================================================
	// gate registers: writable bits only, reserved bits stay zero
	// run set, in force whenever auto gating is off
	always @(posedge clk_sys) begin
		if (rst)
			runGate_q <= `SCG_GATE_RESET;
		else if (wrHit(regWrStb, regAddr, `SCG_OFF_RUN_GATE))
			runGate_q <= regWrData & `SCG_GATE_WMASK;
	end

	// sleep set, used while sleeping with auto gating on
	always @(posedge clk_sys) begin
		if (rst)
			sleepGate_q <= `SCG_GATE_RESET;
		else if (wrHit(regWrStb, regAddr, `SCG_OFF_SLEEP_GATE))
			sleepGate_q <= regWrData & `SCG_GATE_WMASK;
	end

	// deep-sleep set
	always @(posedge clk_sys) begin
		if (rst)
			deepGate_q <= `SCG_GATE_RESET;
		else if (wrHit(regWrStb, regAddr, `SCG_OFF_DEEP_GATE))
			deepGate_q <= regWrData & `SCG_GATE_WMASK;
	end

	// run configuration, only the auto gate select bit is kept
	always @(posedge clk_sys) begin
		if (rst)
			runCfg_q <= `SCG_CFG_RESET;
		else if (wrHit(regWrStb, regAddr, `SCG_OFF_RUN_CFG))
			runCfg_q <= regWrData & `SCG_CFG_WMASK;
	end

	// power mode, an unused code falls back to the run set
	always @(posedge clk_sys) begin
		if (rst)
			powerMode_q <= `SCG_MODE_RUN;
		else if (wrHit(regWrStb, regAddr, `SCG_OFF_MODE))
			powerMode_q <= regWrData[1:0];
	end

	// interrupt mask, same layout as status
	always @(posedge clk_sys) begin
		if (rst)
			mask_q <= {`SCG_EV_WIDTH{1'b0}};
		else if (wrHit(regWrStb, regAddr, `SCG_OFF_MASK))
			mask_q <= regWrData[`SCG_EV_WIDTH-1:0];
	end

	// ======================================================================
	// clock enables and rate from the active set
	// last active set, kept to spot a change of set
	always @(posedge clk_sys) begin
		if (rst)
			activeGate_q <= `SCG_GATE_RESET;
		else
			activeGate_q <= activeGate;
	end

	// pwm clock enable
	always @(posedge clk_sys) begin
		if (rst)
			pwmClkEn <= 1'b0;
		else
			pwmClkEn <= activeGate[`SCG_BIT_PWM];
	end

	// adc clock enable
	always @(posedge clk_sys) begin
		if (rst)
			adcClkEn <= 1'b0;
		else
			adcClkEn <= activeGate[`SCG_BIT_ADC];
	end

	// watchdog clock enable
	always @(posedge clk_sys) begin
		if (rst)
			watchdogClkEn <= 1'b0;
		else
			watchdogClkEn <= activeGate[`SCG_BIT_WDT];
	end

	// hibernate clock enable, on out of reset
	always @(posedge clk_sys) begin
		if (rst)
			hibernateClkEn <= 1'b1;
		else
			hibernateClkEn <= activeGate[`SCG_BIT_HIB];
	end

	// adc sample rate, passed as written, software keeps it legal
	always @(posedge clk_sys) begin
		if (rst)
			adcSampleRate <= 2'h0;
		else
			adcSampleRate <= activeGate[`SCG_RATE_HI:`SCG_RATE_LO];
	end

	assign gateChanged = (activeGate != activeGate_q);

	// ======================================================================
	// fault answer: one-cycle pulse after an access to a gated unit
	assign faultNow = periphAccess && !unitEnabled(activeGate, periphUnit);

	// next state of the fault answer
	always @* begin
		state_d = ST_IDLE;
		case (state_q)
			ST_IDLE: if (faultNow) state_d = ST_FAULT;
			ST_FAULT: if (faultNow) state_d = ST_FAULT;
			default: state_d = ST_IDLE;
		endcase
	end

	// fault answer state
	always @(posedge clk_sys) begin
		if (rst)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// bus fault pulse, one cycle per faulting access cycle
	always @(posedge clk_sys) begin
		if (rst)
			busFault <= 1'b0;
		else
			busFault <= (state_d == ST_FAULT);
	end

	// ======================================================================
	// sticky events, write one to clear, set wins
	assign events = {gateChanged, faultNow};

	always @* begin
		status_d = status_q;
		if (wrHit(regWrStb, regAddr, `SCG_OFF_STATUS))
			status_d = status_q & ~regWrData[`SCG_EV_WIDTH-1:0];
		status_d = status_d | events;
	end

	// sticky status
	always @(posedge clk_sys) begin
		if (rst)
			status_q <= {`SCG_EV_WIDTH{1'b0}};
		else
			status_q <= status_d;
	end

	// level interrupt while an unmasked status bit is set
	always @(posedge clk_sys) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(status_d & mask_q);
	end

	// ======================================================================
	// read mux, unmapped addresses read zero
	always @* begin
		case (regAddr)
			`SCG_OFF_RUN_GATE: rdMux = runGate_q;
			`SCG_OFF_SLEEP_GATE: rdMux = sleepGate_q;
			`SCG_OFF_DEEP_GATE: rdMux = deepGate_q;
			`SCG_OFF_RUN_CFG: rdMux = runCfg_q;
			`SCG_OFF_MODE: rdMux = {30'h0, powerMode_q};
			`SCG_OFF_STATUS: rdMux = {30'h0, status_q};
			`SCG_OFF_MASK: rdMux = {30'h0, mask_q};
			`SCG_OFF_ACTIVE: rdMux = activeGate; // same set that feeds the enables
			default: rdMux = 32'h00000000;
		endcase
	end

	// read data held for the one cycle after the strobe
	always @(posedge clk_sys) begin
		if (rst)
			regRdData <= 32'h00000000;
		else if (regRdStb)
			regRdData <= rdMux;
		else
			regRdData <= 32'h00000000;
	end

endmodule // sleep_clock_gating

// [inc/sleep_clock_gating_regs.vh]
// register map, field positions, reset values and modes of the sleep clock gating block
// assumes a 32-bit register port with word-aligned byte addresses
`ifndef SLEEP_CLOCK_GATING_REGS_VH
`define SLEEP_CLOCK_GATING_REGS_VH

// ==========================================================================
// register offsets
`define SCG_OFF_RUN_GATE 12'h100
`define SCG_OFF_SLEEP_GATE 12'h110
`define SCG_OFF_DEEP_GATE 12'h120
`define SCG_OFF_RUN_CFG 12'h060
`define SCG_OFF_MODE 12'h130
`define SCG_OFF_STATUS 12'h134
`define SCG_OFF_MASK 12'h138
`define SCG_OFF_ACTIVE 12'h13C

// ==========================================================================
// gate register fields
`define SCG_BIT_PWM 20
`define SCG_BIT_ADC 16
`define SCG_BIT_HIB 6
`define SCG_BIT_WDT 3
`define SCG_RATE_HI 9
`define SCG_RATE_LO 8
`define SCG_GATE_WMASK 32'h00110348
`define SCG_GATE_RESET 32'h00000040

// ==========================================================================
// run clock configuration: auto clock gate select bit
`define SCG_BIT_ACG 27
`define SCG_CFG_WMASK 32'h08000000
`define SCG_CFG_RESET 32'h00000000

// ==========================================================================
// power modes as written to the mode register
`define SCG_MODE_RUN 2'h0
`define SCG_MODE_SLEEP 2'h1
`define SCG_MODE_DEEP 2'h2

// ==========================================================================
// status and mask: bit 0 fault event, bit 1 gate set change
`define SCG_EV_FAULT 0
`define SCG_EV_CHANGE 1
`define SCG_EV_WIDTH 2

// ==========================================================================
// unit select codes on the peripheral access port
`define SCG_UNIT_PWM 2'h0
`define SCG_UNIT_ADC 2'h1
`define SCG_UNIT_WDT 2'h2
`define SCG_UNIT_HIB 2'h3

`endif

// [core/gate_set_select.v]
// picks the active gate set for the current power mode
// assumes the three gate registers and the mode come from one clock domain
`timescale 1ns/10ps
`include "sleep_clock_gating_regs.vh"

module gate_set_select (
	input wire [31:0] runGate,
	input wire [31:0] sleepGate,
	input wire [31:0] deepGate,
	input wire [1:0] powerMode,
	input wire autoGateSel,
	output reg [31:0] activeGate
);

	// ======================================================================
	// mode to gate set
	always @* begin
		activeGate = runGate;
		if (autoGateSel) begin
			case (powerMode)
				`SCG_MODE_SLEEP: activeGate = sleepGate;
				`SCG_MODE_DEEP: activeGate = deepGate;
				default: activeGate = runGate;
			endcase
		end // otherwise the run set holds
	end

endmodule // gate_set_select

// [verification/sleep_clock_gating_checker.sv]
// port checker for the sleep clock gating block
// assumes one clock, clk_sys, and synchronous active-high rst
`timescale 1ns/10ps
`include "sleep_clock_gating_regs.vh"
module sleep_clock_gating_checker (
	input wire clk_sys,
	input wire rst,
	input wire [11:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWrStb,
	input wire regRdStb,
	input wire [31:0] regRdData,
	input wire periphAccess,
	input wire [1:0] periphUnit,
	input wire busFault,
	input wire pwmClkEn,
	input wire adcClkEn,
	input wire watchdogClkEn,
	input wire hibernateClkEn,
	input wire [1:0] adcSampleRate,
	input wire irq
);
	// ==================================================
	// helpers
	// access aimed at the pwm, adc or watchdog unit while its enable is low
	wire gatedHit = periphAccess & (periphUnit == 2'h0 & ~pwmClkEn
		| periphUnit == 2'h1 & ~adcClkEn | periphUnit == 2'h2 & ~watchdogClkEn);
	wire [5:0] en = {pwmClkEn, adcClkEn, watchdogClkEn, hibernateClkEn, adcSampleRate};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ==================================================
	// assertions
	a_rd_idle: assert property (!regRdStb |=> regRdData == 32'h0)
		else $error("read data not zero outside read");
	a_fault_gated: assert property (periphAccess && !$past(regWrStb) |=> busFault == $past(gatedHit))
		else $error("fault does not follow gate state");
	a_no_access: assert property (!periphAccess |=> !busFault)
		else $error("fault without access");
	a_hib_free: assert property (periphAccess && periphUnit == 2'h3 |=> !busFault)
		else $error("hibernate access faulted");
	a_reset_vals: assert property ($past(rst) |-> en == 6'h04 && !busFault && !irq)
		else $error("wrong values after reset");
	a_en_hold: assert property (!$past(regWrStb) && !$past(regWrStb, 2) |-> $stable(en))
		else $error("enables moved without a write");
	a_active_echo: assert property (regRdStb && regAddr == `SCG_OFF_ACTIVE |=>
		{regRdData[20], regRdData[16], regRdData[3], regRdData[6], regRdData[9:8]} == en)
		else $error("enables differ from active set");
	a_rsvd_zero: assert property (regRdStb && (regAddr == `SCG_OFF_SLEEP_GATE
		|| regAddr == `SCG_OFF_RUN_GATE || regAddr == `SCG_OFF_DEEP_GATE) |=>
		(regRdData & ~`SCG_GATE_WMASK) == 32'h0)
		else $error("reserved gate bits not zero");
	c_fault: cover property (busFault);
	c_irq: cover property (irq);
	c_rate: cover property (adcSampleRate == 2'h2);
endmodule // sleep_clock_gating_checker

bind sleep_clock_gating sleep_clock_gating_checker chk (.clk_sys(clk_sys), .rst(rst),
	.regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
	.regRdData(regRdData), .periphAccess(periphAccess), .periphUnit(periphUnit),
	.busFault(busFault), .pwmClkEn(pwmClkEn), .adcClkEn(adcClkEn),
	.watchdogClkEn(watchdogClkEn), .hibernateClkEn(hibernateClkEn),
	.adcSampleRate(adcSampleRate), .irq(irq));

// [verification/testbench.sv]
// self-checking bench for the sleep clock gating block
// assumes the register port answers reads one cycle later
`timescale 1ns/10ps
`include "sleep_clock_gating_regs.vh"
module testbench;
	localparam logic [11:0] RG = `SCG_OFF_RUN_GATE, SG = `SCG_OFF_SLEEP_GATE;
	localparam logic [11:0] DG = `SCG_OFF_DEEP_GATE, CF = `SCG_OFF_RUN_CFG, MD = `SCG_OFF_MODE;
	localparam logic [11:0] ST = `SCG_OFF_STATUS, MK = `SCG_OFF_MASK, AC = `SCG_OFF_ACTIVE;
	localparam logic [31:0] WM = `SCG_GATE_WMASK;
	logic clk_sys = 0, rst = 1, regWrStb = 0, regRdStb = 0, periphAccess = 0;
	logic [11:0] regAddr = 0;
	logic [31:0] regWrData = 0, regRdData, gRun, gSlp, gDeep, rnd;
	logic [1:0] periphUnit = 0, adcSampleRate, mode;
	logic busFault, pwmClkEn, adcClkEn, watchdogClkEn, hibernateClkEn, irq, auto_clock_gate_select;
	logic [63:0] rdQ[$];
	logic fltQ[$];
	logic rdP = 0, acP = 0;
	int error_cnt = 0, n_compared = 0, cyc = 0, i, u;
	sleep_clock_gating uut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
		.regRdData(regRdData), .periphAccess(periphAccess), .periphUnit(periphUnit),
		.busFault(busFault), .pwmClkEn(pwmClkEn), .adcClkEn(adcClkEn),
		.watchdogClkEn(watchdogClkEn), .hibernateClkEn(hibernateClkEn),
		.adcSampleRate(adcSampleRate), .irq(irq));
	// ==================================================
	// clock, model and tasks
	initial forever #4 clk_sys = ~clk_sys;
	// expected active gate set
	function automatic logic [31:0] active();
		if (!auto_clock_gate_select || mode == `SCG_MODE_RUN) return gRun;
		return mode == `SCG_MODE_SLEEP ? gSlp : gDeep;
	endfunction
	task automatic cmpVal(input logic [31:0] g, input logic [63:0] n);
		n_compared++;
		if ((g & n[63:32]) !== (n[31:0] & n[63:32])) begin
			error_cnt++;
			$display("MISMATCH %0t value %h expected %h", $time, g, n[31:0]);
		end
	endtask
	task automatic cmpBit(input logic g, input logic e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %0t flag %b expected %b", $time, g, e);
		end
	endtask
	// one bus or access cycle, all strobes set together
	task automatic op(input logic w, r, p, input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] un);
		@(posedge clk_sys);
		regWrStb <= w;
		regRdStb <= r;
		periphAccess <= p;
		regAddr <= a;
		regWrData <= d;
		periphUnit <= un;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		case (a)
			RG: gRun = d & WM;
			SG: gSlp = d & WM;
			DG: gDeep = d & WM;
			CF: auto_clock_gate_select = d[`SCG_BIT_ACG];
			MD: mode = d[1:0];
			default: ;
		endcase
		op(1, 0, 0, a, d, 0);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		rdQ.push_back({m, e});
		op(0, 1, 0, a, 0, 0);
	endtask
	task automatic acc(input logic [1:0] un);
		logic [31:0] a;
		a = active();
		fltQ.push_back(un == 0 ? !a[20] : un == 1 ? !a[16] : un == 2 ? !a[3] : 1'b0);
		op(0, 0, 1, 0, 0, un);
	endtask
	task automatic idle(input int n);
		op(0, 0, 0, 0, 0, 0);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic chkEn();
		logic [31:0] a;
		a = active();
		cmpVal({pwmClkEn, adcClkEn, watchdogClkEn, hibernateClkEn, adcSampleRate},
			{32'h3F, 26'h0, a[20], a[16], a[3], a[6], a[9:8]});
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==================================================
	// result watcher and timeout
	always @(posedge clk_sys) begin
		if (rdP) cmpVal(regRdData, rdQ.pop_front());
		if (acP) cmpBit(busFault, fltQ.pop_front());
		rdP <= regRdStb;
		acP <= periphAccess;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			print_verdict();
		end
	end
	// ==================================================
	// tests
	initial begin
		void'($urandom(32'hEF926E40));
		gRun = 32'h40; gSlp = 32'h40; gDeep = 32'h40; auto_clock_gate_select = 0; mode = 0;
		repeat (4) @(posedge clk_sys);
		rst <= 0;
		rd(RG, 32'h40, '1); rd(SG, 32'h40, '1); rd(DG, 32'h40, '1);
		rd(CF, 0, '1); rd(AC, 32'h40, '1); idle(2); chkEn();
		$display("test 1 done");
		for (i = 0; i < 8; i++) begin
			rnd = $urandom;
			if (rnd[9:8] == 2'h3)
				rnd[9] = 1'b0;
			wr(SG, rnd); rd(SG, rnd & WM, '1);
			rd(AC, active(), '1);
		end
		wr(12'h200, $urandom); rd(12'h200, 0, '1); idle(2); chkEn();
		$display("test 2 done");
		wr(RG, 32'h00010148); wr(SG, 32'h00100200); wr(DG, 32'h00010108);
		for (i = 0; i < 6; i++) begin
			wr(CF, (i / 3) << `SCG_BIT_ACG); wr(MD, i % 3); rd(AC, active(), '1);
			idle(2); chkEn();
			for (u = 0; u < 4; u++) acc(u);
		end
		$display("test 3 done");
		wr(MK, 1); wr(ST, 3); idle(2); cmpBit(irq, 0);
		acc(`SCG_UNIT_PWM); idle(2); cmpBit(irq, 1);
		rd(ST, 1, 1); wr(ST, 1); idle(2); cmpBit(irq, 0);
		wr(MK, 0); acc(`SCG_UNIT_PWM); idle(2); cmpBit(irq, 0);
		wr(MD, 1); idle(1); rd(ST, 2, 2); idle(2); chkEn();
		$display("test 4 done");
		print_verdict();
	end
endmodule // testbench
